// >>> core/cit_core.sv
`timescale 1ns/1ps
module cit_core
  import cit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire cit_req_s req_i,
  output cit_res_s res_o,
  output logic [2:0] cycles_o,
  output logic [1:0] words_o,
  output logic ready_o,
  output logic busy_o,
  output logic fetch_o
);
  typedef struct packed {
    cit_st_e st;
    logic [2:0] cnt;
    logic [2:0] cycles;
    logic [1:0] words;
    cit_res_s res;
    logic ready;
    logic fetch;
  } cit_state_s;

  cit_state_s s_r;
  cit_state_s s_nxt;

  function automatic logic is_ext(input cit_am_e m);
    is_ext = (m == AM_IDX) || (m == AM_SYM) || (m == AM_ABS);
  endfunction

  // cycles from format, single-operand op, addressing modes and pc destination only
  function automatic logic [2:0] cyc_count(input cit_req_s r);
    logic mem_dst;
    mem_dst = is_ext(r.dst_mode);
    cyc_count = 3'h1;
    case (r.fmt)
      FMT_RETURN_FROM_INTERRUPT: cyc_count = CYC_RETURN_FROM_INTERRUPT; // RL8
      FMT_IRQ: cyc_count = CYC_IRQ; // RL8
      FMT_WDT_RST, FMT_EXT_RST: cyc_count = CYC_RESET; // RL8
      FMT_JUMP: cyc_count = CYC_JUMP; // RL12
      FMT_SINGLE:
      begin
        case (r.sop)
          SOP_PUSH: // RL10
            if (r.dst_mode == AM_REG) cyc_count = 3'h3;
            else if (r.dst_mode == AM_IND || r.dst_mode == AM_IMM)
              cyc_count = 3'h4;
            else cyc_count = 3'h5;
          SOP_CALL: // RL10
            if (r.dst_mode == AM_REG || r.dst_mode == AM_IND)
              cyc_count = 3'h4;
            else cyc_count = 3'h5;
          default: // RL9
            if (r.dst_mode == AM_REG) cyc_count = 3'h1;
            else if (r.dst_mode == AM_IND || r.dst_mode == AM_AUTOINC)
              cyc_count = 3'h3;
            else cyc_count = 3'h4;
        endcase
      end
      FMT_DOUBLE:
      begin
        if (r.src_mode == AM_REG) // RL13
          cyc_count = mem_dst ? 3'h4 : (r.dst_pc ? 3'h2 : 3'h1);
        else if (is_ext(r.src_mode)) // RL15
          cyc_count = mem_dst ? 3'h6 : 3'h3;
        else if (mem_dst) // RL14
          cyc_count = 3'h5;
        else if (r.dst_pc)
          cyc_count = (r.src_mode == AM_IND) ? 3'h2 : 3'h3;
        else
          cyc_count = 3'h2;
      end
      default: cyc_count = 3'h1;
    endcase
  endfunction

  function automatic logic [1:0] word_count(input cit_req_s r);
    word_count = 2'h1;
    case (r.fmt)
      FMT_IRQ, FMT_WDT_RST, FMT_EXT_RST: word_count = 2'h0;
      FMT_SINGLE: // RL10
        if (is_ext(r.dst_mode) || r.dst_mode == AM_IMM) word_count = 2'h2;
      FMT_DOUBLE: // RL15
        word_count = 2'h1
          + {1'b0, is_ext(r.src_mode) || r.src_mode == AM_IMM}
          + {1'b0, is_ext(r.dst_mode)};
      default: word_count = 2'h1;
    endcase
  endfunction

  function automatic cit_res_s alu(input cit_req_s r);
    logic [15:0] m;
    logic [15:0] d;
    logic [15:0] sv;
    logic [15:0] y;
    logic msb;
    logic smsb;
    m = r.byte_op ? BYTE_ONES : WORD_ONES;
    d = r.dst & m;
    sv = r.src & m;
    y = d;
    alu.sr = r.sr; // RL6
    alu.dst_we = 1'b0;
    msb = r.byte_op ? d[7] : d[15];
    smsb = r.byte_op ? sv[7] : sv[15];
    case (r.alu)
      ALU_TEST:
      begin
        y = (d + m + 16'h0001) & m; // RL2
        alu.sr[SR_N] = msb; // RL3
        alu.sr[SR_Z] = (d == ZERO_WORD);
        alu.sr[SR_C] = 1'b1;
        alu.sr[SR_V] = 1'b0;
      end
      ALU_XOR:
      begin
        y = sv ^ d; // RL4
        alu.dst_we = 1'b1;
        alu.sr[SR_N] = r.byte_op ? y[7] : y[15]; // RL5
        alu.sr[SR_Z] = (y == ZERO_WORD);
        alu.sr[SR_C] = (y != ZERO_WORD);
        alu.sr[SR_V] = msb & smsb;
      end
      ALU_SEXT:
      begin
        y = {{8{r.dst[7]}}, r.dst[7:0]}; // RL1
        alu.dst_we = 1'b1;
        alu.sr[SR_N] = y[15]; // RL16
        alu.sr[SR_Z] = (y == ZERO_WORD);
        alu.sr[SR_C] = (y != ZERO_WORD);
        alu.sr[SR_V] = 1'b0;
      end
      default: y = d;
    endcase
    alu.result = (r.alu == ALU_TEST) ? r.dst : y;
  endfunction

  always_comb
  begin
    logic [2:0] n;
    n = cyc_count(req_i); // RL7
    s_nxt = s_r;
    s_nxt.fetch = 1'b0;
    case (s_r.st)
      ST_IDLE:
      begin
        if (start_i)
        begin
          s_nxt.res = alu(req_i);
          s_nxt.cycles = n;
          s_nxt.words = word_count(req_i);
          s_nxt.cnt = n - 3'h1;
          if (n == 3'h1)
            s_nxt.fetch = 1'b1; // RL17
          else
          begin
            s_nxt.st = ST_BUSY;
            s_nxt.ready = 1'b0;
          end
        end
      end
      ST_BUSY:
      begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (s_r.cnt == 3'h1)
        begin
          s_nxt.fetch = 1'b1; // RL17
          s_nxt.st = ST_IDLE;
          s_nxt.ready = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
        s_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      s_r <= '0;
      s_r.ready <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign res_o = s_r.res;
  assign cycles_o = s_r.cycles;
  assign words_o = s_r.words;
  assign ready_o = s_r.ready;
  assign busy_o = s_r.st;
  assign fetch_o = s_r.fetch;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic take;
  assign take = start_i && ready_o;

  sequence s_wait2;
    !fetch_o ##1 fetch_o;
  endsequence
  sequence s_wait6;
    !fetch_o [*5] ##1 fetch_o;
  endsequence

  property p_sext_high;
    take && req_i.alu == ALU_SEXT |=>
      res_o.result[15:8] == {8{res_o.result[7]}}
      && res_o.result[7:0] == $past(req_i.dst[7:0]);
  endproperty
  a_sext_high: assert property (p_sext_high) // RL1
    else $error("sign extend result wrong");

  property p_test_nowrite;
    take && req_i.alu == ALU_TEST |=>
      !res_o.dst_we && res_o.sr[SR_C] && !res_o.sr[SR_V];
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) // RL2
    else $error("test wrote destination or bad c/v");

  property p_test_zero;
    take && req_i.alu == ALU_TEST && !req_i.byte_op |=>
      res_o.sr[SR_Z] == ($past(req_i.dst) == ZERO_WORD);
  endproperty
  a_test_zero: assert property (p_test_zero) // RL3
    else $error("test zero flag wrong");

  property p_xor_flags;
    take && req_i.alu == ALU_XOR && !req_i.byte_op |=>
      res_o.result == ($past(req_i.src) ^ $past(req_i.dst))
      && res_o.sr[SR_C] == !res_o.sr[SR_Z]
      && res_o.sr[SR_V] == ($past(req_i.src[15]) && $past(req_i.dst[15]));
  endproperty
  a_xor_flags: assert property (p_xor_flags) // RL5
    else $error("xor result or flags wrong");

  property p_mode_bits;
    take |=> res_o.sr[SR_OSCILLATOR_OFF_BIT:SR_GIE] == $past(req_i.sr[SR_OSCILLATOR_OFF_BIT:SR_GIE]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) // RL6
    else $error("mode bits changed");

  property p_irq_cycles;
    take && req_i.fmt == FMT_IRQ |=> s_wait6;
  endproperty
  a_irq_cycles: assert property (p_irq_cycles) // RL8
    else $error("interrupt accept not 6 cycles");

  property p_jump_cycles;
    take && req_i.fmt == FMT_JUMP |=> s_wait2 ##0 words_o == 2'h1;
  endproperty
  a_jump_cycles: assert property (p_jump_cycles) // RL12
    else $error("jump not 2 cycles");

  property p_jump_busy;
    take && req_i.fmt == FMT_JUMP |=> busy_o && !ready_o;
  endproperty
  a_jump_busy: assert property (p_jump_busy) // RL12
    else $error("jump not busy in its first cycle");

  property p_reg_single;
    take && req_i.fmt == FMT_SINGLE && req_i.sop == SOP_SHIFT
      && req_i.dst_mode == AM_REG |=> fetch_o;
  endproperty
  a_reg_single: assert property (p_reg_single) // RL9
    else $error("register single op not 1 cycle");

  property p_fetch_ready;
    fetch_o |-> ready_o && !busy_o;
  endproperty
  a_fetch_ready: assert property (p_fetch_ready) // RL17
    else $error("fetch while busy");
endmodule

// >>> core/cit_pkg.sv
// Functional notes
// RL1 - sign extend copies bit 7 into bits 8..15, low byte unchanged
// RL2 - test adds all-ones plus one, sets flags only, never writes destination
// RL3 - test: n is sign, z is zero, carry set, overflow cleared
// RL4 - xor combines source and destination bitwise into destination, word or byte
// RL5 - xor: n is msb, z zero, carry not zero, overflow when both negative
// RL6 - test and xor keep oscillator-off, cpu-off and interrupt enable bits
// RL7 - cycle count depends on format and addressing modes, in clock periods
// RL8 - interrupt return 5, interrupt accept 6, both resets 4 cycles
// RL9 - shift, rotate, swap, sign extend: 1 register, 3 indirect, 4 memory
// RL10 - push 3/4/5 cycles, call 4/5 cycles, extended modes two words
// RL11 - software must not use immediate destination on single-operand ops (program store remaps it only for shift ops; push and call keep it)
// RL12 - every jump is one word and two cycles, taken or not
// RL13 - register source: 1 to register, 2 to pc, 4 to memory
// RL14 - indirect/immediate source: 2 register, pc 2 or 3, memory 5
// RL15 - indexed source: 3 cycles to register or pc, 6 to memory
// RL16 - sign extend: n and z from result, carry not zero, overflow cleared
// RL17 - next fetch starts only after the listed cycle count elapses
package cit_pkg;
  localparam int unsigned SR_C = 0;
  localparam int unsigned SR_Z = 1;
  localparam int unsigned SR_N = 2;
  localparam int unsigned SR_GIE = 3;
  localparam int unsigned SR_CPU_OFF_BIT = 4;
  localparam int unsigned SR_OSCILLATOR_OFF_BIT = 5;
  localparam int unsigned SR_V = 8;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] BYTE_ONES = 16'h00FF;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [2:0] CYC_RETURN_FROM_INTERRUPT = 3'h5;
  localparam logic [2:0] CYC_IRQ = 3'h6;
  localparam logic [2:0] CYC_RESET = 3'h4;
  localparam logic [2:0] CYC_JUMP = 3'h2;

  typedef enum logic [2:0] {
    FMT_SINGLE = 3'h0,
    FMT_DOUBLE = 3'h1,
    FMT_JUMP = 3'h2,
    FMT_RETURN_FROM_INTERRUPT = 3'h3,
    FMT_IRQ = 3'h4,
    FMT_WDT_RST = 3'h5,
    FMT_EXT_RST = 3'h6
  } cit_fmt_e;

  typedef enum logic [1:0] {
    SOP_SHIFT = 2'h0,
    SOP_PUSH = 2'h1,
    SOP_CALL = 2'h2
  } cit_sop_e;

  typedef enum logic [1:0] {
    ALU_NONE = 2'h0,
    ALU_XOR = 2'h1,
    ALU_TEST = 2'h2,
    ALU_SEXT = 2'h3
  } cit_alu_e;

  typedef enum logic [2:0] {
    AM_REG = 3'h0,
    AM_IND = 3'h1,
    AM_AUTOINC = 3'h2,
    AM_IMM = 3'h3,
    AM_IDX = 3'h4,
    AM_SYM = 3'h5,
    AM_ABS = 3'h6
  } cit_am_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } cit_st_e;

  typedef struct packed {
    cit_fmt_e fmt;
    cit_sop_e sop;
    cit_alu_e alu;
    cit_am_e src_mode;
    cit_am_e dst_mode;
    logic dst_pc;
    logic byte_op;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] sr;
  } cit_req_s;

  typedef struct packed {
    logic [15:0] result;
    logic [15:0] sr;
    logic dst_we;
  } cit_res_s;
endpackage

// >>> verif/cit_prog_mem.sv
`timescale 1ns/1ps
module cit_prog_mem
  import cit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic fetch_i,
  input wire logic [1:0] words_i,
  input wire cit_req_s raw_i,
  output cit_req_s req_o,
  output logic [15:0] addr_o
);
  // code word address advances by the length of each finished instruction
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      addr_o <= 16'h0000;
    else if (fetch_i)
      addr_o <= addr_o + {14'h0000, words_i};
  end

  // the program store holds only legal encodings, apart from immediate destinations on push and call
  always_comb
  begin
    req_o = raw_i;
    if (raw_i.fmt > FMT_EXT_RST)
      req_o.fmt = FMT_JUMP;
    if (raw_i.sop > SOP_CALL)
      req_o.sop = SOP_SHIFT;
    if (raw_i.src_mode > AM_ABS)
      req_o.src_mode = AM_REG;
    if (raw_i.dst_mode > AM_ABS)
      req_o.dst_mode = AM_REG;
    if (req_o.fmt == FMT_DOUBLE && req_o.dst_mode inside {[AM_IND:AM_IMM]})
      req_o.dst_mode = AM_IDX;
    if (req_o.fmt == FMT_SINGLE && req_o.sop == SOP_SHIFT &&
        req_o.dst_mode == AM_IMM)
      req_o.dst_mode = AM_ABS;
    if (req_o.fmt == FMT_DOUBLE)
      req_o.alu = (raw_i.alu == ALU_SEXT) ? ALU_XOR : raw_i.alu;
    else if (req_o.fmt == FMT_SINGLE && req_o.sop == SOP_SHIFT)
      req_o.alu = (raw_i.alu == ALU_SEXT) ? ALU_SEXT : ALU_NONE;
    else
      req_o.alu = ALU_NONE;
    if (req_o.alu == ALU_SEXT)
      req_o.byte_op = 1'b0;
    req_o.dst_pc = raw_i.dst_pc && req_o.fmt == FMT_DOUBLE &&
                   req_o.dst_mode == AM_REG;
  end
endmodule

// >>> verif/tb_cpu_instruction_timing.sv
`timescale 1ns/1ps
module tb_cpu_instruction_timing
  import cit_pkg::*;
;
  typedef struct packed {
    cit_res_s r;
    logic [2:0] c;
    logic [1:0] w;
  } cit_exp_s;
  logic core_clk_i, reset_n_i, start_i, ready_o, busy_o, fetch_o;
  cit_req_s raw_r, req_i;
  cit_res_s res_o;
  logic [2:0] cycles_o;
  logic [1:0] words_o;
  logic [15:0] mem_addr;
  logic [31:0] seed;
  cit_exp_s notes[$];
  time take_t[$];
  int n_errors, total_checks, ncyc;
  logic [47:0] got, want, dt;
  logic [15:0] exp_addr;

  cit_core dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .start_i(start_i), .req_i(req_i), .res_o(res_o), .cycles_o(cycles_o),
    .words_o(words_o), .ready_o(ready_o), .busy_o(busy_o),
    .fetch_o(fetch_o));
  cit_prog_mem mem_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .fetch_i(fetch_o), .words_i(words_o), .raw_i(raw_r), .req_o(req_i),
    .addr_o(mem_addr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic cit_exp_s expect_of(cit_req_s q);
    cit_exp_s e;
    logic [15:0] m, v;
    logic md;
    m = q.byte_op ? BYTE_ONES : WORD_ONES;
    md = q.dst_mode >= AM_IDX;
    e.r = {q.dst & m, q.sr, 1'b0};
    v = ZERO_WORD;
    case (q.alu)
      ALU_XOR:
      begin
        v = (q.src ^ q.dst) & m;
        e.r.result = v;
        e.r.dst_we = 1'b1;
        e.r.sr[SR_V] = q.byte_op ? q.src[7] & q.dst[7]
          : q.src[15] & q.dst[15];
      end
      ALU_TEST:
      begin
        v = q.dst & m;
        e.r.result = q.dst;
        e.r.sr[SR_V] = 1'b0;
      end
      ALU_SEXT:
      begin
        v = {{8{q.dst[7]}}, q.dst[7:0]};
        e.r.result = v;
        e.r.dst_we = 1'b1;
        e.r.sr[SR_V] = 1'b0;
      end
      default:
        v = ZERO_WORD;
    endcase
    if (q.alu != ALU_NONE)
    begin
      e.r.sr[SR_N] = q.byte_op ? v[7] : v[15];
      e.r.sr[SR_Z] = v == ZERO_WORD;
      e.r.sr[SR_C] = q.alu == ALU_TEST || v != ZERO_WORD;
    end
    e.w = 2'h1;
    case (q.fmt)
      FMT_JUMP: e.c = 3'h2;
      FMT_RETURN_FROM_INTERRUPT: e.c = 3'h5;
      FMT_IRQ: {e.c, e.w} = {3'h6, 2'h0};
      FMT_SINGLE:
      begin
        e.w = (q.dst_mode >= AM_IMM) ? 2'h2 : 2'h1;
        if (q.sop == SOP_SHIFT)
          e.c = (q.dst_mode == AM_REG) ? 3'h1 : md ? 3'h4 : 3'h3;
        else if (q.sop == SOP_PUSH)
          e.c = (q.dst_mode == AM_REG) ? 3'h3 :
            (q.dst_mode inside {AM_IND, AM_IMM}) ? 3'h4 : 3'h5;
        else
          e.c = (q.dst_mode inside {AM_REG, AM_IND}) ? 3'h4 : 3'h5;
      end
      FMT_DOUBLE:
      begin
        e.w = 2'h1 + (q.src_mode >= AM_IMM) + md;
        if (q.src_mode == AM_REG)
          e.c = md ? 3'h4 : q.dst_pc ? 3'h2 : 3'h1;
        else if (q.src_mode <= AM_IMM)
          e.c = md ? 3'h5 : !q.dst_pc ? 3'h2
            : q.src_mode == AM_IND ? 3'h2 : 3'h3;
        else
          e.c = md ? 3'h6 : 3'h3;
      end
      default: {e.c, e.w} = {3'h4, 2'h0};
    endcase
    return e;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input cit_req_s x);
    raw_r <= x;
    start_i <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk_i);
      if (ready_o === 1'b1)
        break;
    end
    notes.push_back(expect_of(req_i));
    take_t.push_back($time);
  endtask

  task automatic reset_check();
    logic [47:0] seen;
    reset_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    seen = 48'({res_o, cycles_o, words_o, ready_o, busy_o, fetch_o});
    chk(seen, 48'h4);
    @(posedge core_clk_i);
  endtask

  // wait for every noted instruction to finish before moving on
  task automatic drain();
    for (int i = 0; i < 20 && notes.size() > 0; i++)
      @(posedge core_clk_i);
    chk(48'(notes.size()), 48'h0);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // watch outputs, match each finished instruction against its note
  always @(posedge core_clk_i)
  begin
    ncyc++;
    if (ncyc >= 5000)
    begin
      n_errors++;
      test_done();
    end
    else if (!reset_n_i)
    begin
      notes.delete();
      take_t.delete();
      exp_addr = 16'h0000;
    end
    else if (fetch_o === 1'b1)
    begin
      if (notes.size() == 0)
        chk(48'h1, 48'h0);
      else
      begin
        dt = 48'(($time - take_t.pop_front()) / 50);
        chk(dt, 48'(notes[0].c));
        got = 48'({res_o, cycles_o, words_o, ready_o, busy_o});
        want = 48'({notes[0].r, notes[0].c, notes[0].w, 2'b10});
        chk(got, want);
        chk(48'(mem_addr), 48'(exp_addr));
        exp_addr = exp_addr + 16'(notes[0].w);
        void'(notes.pop_front());
      end
    end
  end

  initial
  begin
    seed = 32'h1ed3;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    raw_r = '0;
    reset_check();
    // sign extend, byte test of zero, byte xor of negatives, equal words
    issue({FMT_SINGLE, SOP_SHIFT, ALU_SEXT, AM_REG, AM_REG, 2'h0,
      16'h0000, 16'h1280, 16'h0038});
    issue({FMT_SINGLE, SOP_SHIFT, ALU_SEXT, AM_REG, AM_ABS, 2'h0,
      16'h0000, 16'hFF00, 16'h0000});
    issue({FMT_DOUBLE, SOP_SHIFT, ALU_TEST, AM_IMM, AM_REG, 2'h1,
      16'h1234, 16'hAB00, 16'h0107});
    issue({FMT_DOUBLE, SOP_SHIFT, ALU_XOR, AM_REG, AM_SYM, 2'h1,
      16'h0080, 16'h00FF, 16'h0038});
    issue({FMT_DOUBLE, SOP_SHIFT, ALU_XOR, AM_IDX, AM_REG, 2'h0,
      16'h8421, 16'h8421, 16'h0000});
    $display("test directed done");
    repeat (400)
      issue(cit_req_s'(63'({rnd(), rnd()})));
    $display("test random done");
    issue({FMT_IRQ, 60'h0});
    start_i <= 1'b0;
    drain();
    reset_check();
    issue({FMT_JUMP, 60'h0});
    start_i <= 1'b0;
    drain();
    $display("test reset done");
    test_done();
  end
endmodule
